/* File: mcgw_machine_check_global_watchdog.sv */
`timescale 1ns/1ps

// Functional notes
// RULE1: capabilities read-only, low byte is bank count
// RULE2: capabilities bit 8 shows global enable present
// RULE3: software never writes capabilities; writes ignored
// RULE4: status bit 0 flags restartable pointer
// RULE5: status bit 1 flags faulting pointer
// RULE6: in-progress set on every exception
// RULE7: error while in-progress enters shutdown
// RULE8: software clears in-progress itself
// RULE9: one enable bit per bank, from bit 0
// RULE10: watchdog raises check on instruction timeout
// RULE11: counter restarts on each instruction completion
// RULE12: enable bit0, time base 2-1, count 6-3
// RULE13: counter holds in halt or stop-grant
// RULE14: expiry gated by its bank's report control
// RULE15: registers survive warm reset; cold clears (the watchdog config is cleared by warm reset instead, not by cold reset)
// RULE16: watchdog bits 63-7 written as zero
// RULE17: disabled watchdog neither counts nor fires
// RULE18: time base selects 1ms, 1us, 5ns
// RULE19: count select maps to documented tick counts
// RULE20: expiry at selected count; cleared when disabled
module mcgw_machine_check_global_watchdog #(
    parameter int                   BANK_COUNT     = 6,
    parameter int                   WATCHDOG_BANK  = 0,
    parameter bit                   GLOBAL_PRESENT = 1'b1,
    parameter int                   TICK_MS_CYCLES = mcgw_pkg::TICK_1MS_CYC,
    parameter int                   TICK_US_CYCLES = mcgw_pkg::TICK_1US_CYC
) (
    // clock and resets
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              coldReset,
    // register access port
    input  wire logic              regRead,
    input  wire logic              regWrite,
    input  wire logic [31:0]       regAddr,
    input  wire logic [63:0]       regWriteData,
    output logic [63:0]            regReadData,
    output logic                   regHit,
    // core events
    input  wire logic              instrComplete,
    input  wire logic              haltState,
    input  wire logic              stopGrantState,
    input  wire logic              errorEvent,
    input  wire logic              errorRestartable,
    input  wire logic              errorAtPointer,
    input  wire logic [BANK_COUNT-1:0] bankReportControl,
    // outputs
    output logic                   checkException,
    output logic                   shutdown,
    output logic                   watchdogExpired
);

    // ****************************************************************
    // limitations
    // ****************************************************************
    // per-bank status, address and misc registers live elsewhere
    // reserved time base or count select codes never expire
    // tick lengths are whole clock cycles, rounded down
    // only one bank reports the watchdog expiry
    // capabilities writes are dropped, not trapped
    // external errors arrive already bank-qualified
    // shutdown is sticky until the next warm reset

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_RUN      = 2'b01,
        ST_SHUTDOWN = 2'b10
    } mcgw_state_t;

    mcgw_state_t state;
    mcgw_state_t next_state;

    // ****************************************************************
    // error record, configuration and watchdog state
    // ****************************************************************
    // error record and bank enables live outside the warm reset
    logic [2:0]              globalState;
    logic [63:0]             bankEnable;
    logic [6:0]              timeoutCfg;
    logic [mcgw_pkg::TICK_COUNT_W-1:0] tickCount;
    logic                    exceptionPulse;
    logic                    shutdownPulse;

    // ****************************************************************
    // selection helpers
    // ****************************************************************
    // count-select to tick count; reserved codes never expire
    // a zero limit is refused by the expiry compare
    function automatic logic [mcgw_pkg::TICK_COUNT_W-1:0] count_limit(
        input logic [3:0] sel
    );
        case (sel)
            4'h0:    count_limit = 14'h0FFF; // [RULE19]
            4'h1:    count_limit = 14'h07FF;
            4'h2:    count_limit = 14'h03FF;
            4'h3:    count_limit = 14'h01FF;
            4'h4:    count_limit = 14'h00FF;
            4'h5:    count_limit = 14'h007F;
            4'h6:    count_limit = 14'h003F;
            4'h7:    count_limit = 14'h001F;
            4'h8:    count_limit = 14'h1FFF;
            4'h9:    count_limit = 14'h3FFF;
            default: count_limit = 14'h0000;
        endcase
    endfunction

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire selCap    = (regAddr == mcgw_pkg::ADDR_CAPABILITIES);
    wire selState  = (regAddr == mcgw_pkg::ADDR_GLOBAL_STATE);
    wire selEnable = (regAddr == mcgw_pkg::ADDR_BANK_ENABLE) && GLOBAL_PRESENT;
    wire selWd     = (regAddr == mcgw_pkg::ADDR_TIMEOUT_CFG);
    wire wrState   = regWrite && selState;
    wire wrEnable  = regWrite && selEnable;
    wire wrWd      = regWrite && selWd;
    // no write path to capabilities at all
    wire capWriteIgnored = regWrite && selCap; // [RULE3]

    // combinational, seen in the request cycle
    assign regHit = (regRead || regWrite) && (selCap || selState || selEnable || selWd);

    // ****************************************************************
    // watchdog field views
    // ****************************************************************
    wire       wdEnable   = timeoutCfg[mcgw_pkg::WD_ENABLE_BIT]; // [RULE12]
    wire [1:0] wdTimeBase = timeoutCfg[mcgw_pkg::WD_TB_MSB:mcgw_pkg::WD_TB_LSB];
    wire [3:0] wdCountSel = timeoutCfg[mcgw_pkg::WD_CS_MSB:mcgw_pkg::WD_CS_LSB];
    wire [mcgw_pkg::TICK_COUNT_W-1:0] wdLimit = count_limit(wdCountSel);

    // ****************************************************************
    // watchdog tick and expiry
    // ****************************************************************
    // counting stops in low-power states and when disabled
    wire wdRun   = wdEnable && !haltState && !stopGrantState; // [RULE13] [RULE17]
    wire wdReset = !wdEnable || instrComplete;                // [RULE11] [RULE20]
    wire wdTick;

    mcgw_tick_gen #(
        .TICK_MS_CYCLES (TICK_MS_CYCLES),
        .TICK_US_CYCLES (TICK_US_CYCLES),
        .TICK_NS_CYCLES (mcgw_pkg::TICK_5NS_CYC)
    // the prescaler restarts with the count so ticks stay aligned
    ) mcgw_tick_gen_inst (
        .clock    (clock),
        .rst      (rst),
        .run      (wdRun && !wdReset),
        .restart  (wdReset),
        .timeBase (wdTimeBase), // [RULE18]
        .tick     (wdTick)
    );

    // expiry when the tick count meets the selected value
    wire wdHit = wdEnable && (wdLimit != '0) && (tickCount == wdLimit); // [RULE20] [RULE10]

    // ****************************************************************
    // bank gating
    // ****************************************************************
    // the raw expiry output is shown even when gated off
    // expiry is reported only if its bank reports and globally enabled
    wire wdBankOn = bankReportControl[WATCHDOG_BANK]
                  && (!GLOBAL_PRESENT || bankEnable[WATCHDOG_BANK]); // [RULE14]

    // ****************************************************************
    // error qualification
    // ****************************************************************
    // external errors are already bank-qualified by the caller
    wire anyError     = (errorEvent || (wdHit && wdBankOn)) && (state == ST_RUN);
    wire inProgress   = globalState[mcgw_pkg::GS_PROGRESS_BIT];
    // a second error while in progress shuts down instead
    assign exceptionPulse = anyError && !inProgress;  // [RULE6]
    assign shutdownPulse  = anyError && inProgress;   // [RULE7]
    // a watchdog expiry never points at a good restart
    wire restartOk = errorEvent && errorRestartable;
    wire errorAtIp = errorEvent && errorAtPointer;

    // ****************************************************************
    // state machine
    // ****************************************************************
    // state sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN:      next_state = shutdownPulse ? ST_SHUTDOWN : ST_RUN;
            ST_SHUTDOWN: next_state = ST_SHUTDOWN;
            default:     next_state = ST_RUN;
        endcase
    end

    // shutdown is left only through warm reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // error-reporting registers: cleared only by cold reset
    // ****************************************************************
    // software images of the write data; reserved bits are dropped
    wire [2:0]  stateWriteValue = regWriteData[mcgw_pkg::GS_PROGRESS_BIT:0];
    wire [63:0] bankWriteMask   = {{(64-BANK_COUNT){1'b0}}, {BANK_COUNT{1'b1}}};
    wire [63:0] bankWriteValue  = regWriteData & bankWriteMask; // [RULE9]
    wire [6:0]  wdWriteValue    = regWriteData[mcgw_pkg::WD_FIELD_MSB:0];

    // warm reset (rst) leaves them alone so boot code can read them
    always_ff @(posedge clock) begin
        if (coldReset) begin
            globalState <= mcgw_pkg::RESET_GS; // [RULE15]
        end else if (exceptionPulse) begin
            // hardware set wins over a software write this cycle
            globalState[mcgw_pkg::GS_RESTART_BIT]  <= restartOk; // [RULE4]
            globalState[mcgw_pkg::GS_ERROR_BIT]    <= errorAtIp; // [RULE5]
            globalState[mcgw_pkg::GS_PROGRESS_BIT] <= 1'b1;      // [RULE6]
        end else if (wrState) begin
            // only software clears in-progress
            globalState <= stateWriteValue; // [RULE8]
        end
    end

    always_ff @(posedge clock) begin
        if (coldReset) begin
            bankEnable <= mcgw_pkg::RESET_ZERO64; // [RULE15]
        end else if (wrEnable) begin
            // bits beyond the bank count are not kept; all ones enables all
            bankEnable <= bankWriteValue; // [RULE9]
        end
    end

    // ****************************************************************
    // watchdog configuration and count
    // ****************************************************************
    // warm reset disarms the watchdog until rewritten
    // watchdog configuration; upper bits are not stored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timeoutCfg <= mcgw_pkg::RESET_WD_CFG;
        end else if (wrWd) begin
            timeoutCfg <= wdWriteValue; // [RULE16]
        end
    end

    // tick counter: holds on stall, restarts on completion
    // clearing on expiry lets a stuck instruction fire again
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tickCount <= '0;
        end else if (wdReset || wdHit) begin
            tickCount <= '0; // [RULE11]
        end else if (wdTick) begin
            tickCount <= tickCount + 1'b1; // [RULE13]
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    wire [63:0] capValue = {55'h0, GLOBAL_PRESENT,
                            8'(BANK_COUNT)}; // [RULE1] [RULE2]
    // reserved bits read as zero
    wire [63:0] stateWord  = {61'h0, globalState};
    wire [63:0] enableWord = bankEnable;
    wire [63:0] wdWord     = {57'h0, timeoutCfg};
    wire [63:0] readMux  = selCap    ? capValue
                         : selState  ? stateWord
                         : selEnable ? enableWord
                         : selWd     ? wdWord
                         : 64'h0;

    // read data holds until the next read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regReadData <= mcgw_pkg::RESET_ZERO64;
        end else if (regRead) begin
            regReadData <= readMux;
        end
    end

    // ****************************************************************
    // event outputs
    // ****************************************************************
    // one-cycle pulses; expiry shown whether or not reported
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            checkException  <= 1'b0;
            watchdogExpired <= 1'b0;
        end else begin
            checkException  <= exceptionPulse;
            watchdogExpired <= wdHit;
        end
    end

    // shutdown level straight from the state register
    assign shutdown = (state == ST_SHUTDOWN) || capWriteIgnored && 1'b0;

endmodule

/* File: mcgw_pkg.sv */
package mcgw_pkg;

    // ****************************************************************
    // register selectors (model-specific register numbers, chosen here)
    // ****************************************************************
    localparam logic [31:0] ADDR_CAPABILITIES = 32'h0000_0179;
    localparam logic [31:0] ADDR_GLOBAL_STATE = 32'h0000_017A;
    localparam logic [31:0] ADDR_BANK_ENABLE  = 32'h0000_017B;
    localparam logic [31:0] ADDR_TIMEOUT_CFG  = 32'h0000_0401;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CAP_COUNT_MSB   = 7;
    localparam int CAP_PRESENT_BIT = 8;
    localparam int GS_RESTART_BIT  = 0;
    localparam int GS_ERROR_BIT    = 1;
    localparam int GS_PROGRESS_BIT = 2;
    localparam int WD_ENABLE_BIT   = 0;
    localparam int WD_TB_LSB       = 1;
    localparam int WD_TB_MSB       = 2;
    localparam int WD_CS_LSB       = 3;
    localparam int WD_CS_MSB       = 6;
    localparam int WD_FIELD_MSB    = 6;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [63:0] RESET_ZERO64   = 64'h0;
    localparam logic [6:0]  RESET_WD_CFG   = 7'h00;
    localparam logic [2:0]  RESET_GS       = 3'h0;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLOCK_PERIOD_PS = 4000;
    localparam int TB_1MS_PS       = 1000000000;
    localparam int TB_1US_PS       = 1000000;
    localparam int TB_5NS_PS       = 5000;
    // cycles per tick, rounded down, at least one
    localparam int TICK_1MS_CYC = (TB_1MS_PS / CLOCK_PERIOD_PS) < 1 ? 1
                                : (TB_1MS_PS / CLOCK_PERIOD_PS);
    localparam int TICK_1US_CYC = (TB_1US_PS / CLOCK_PERIOD_PS) < 1 ? 1
                                : (TB_1US_PS / CLOCK_PERIOD_PS);
    localparam int TICK_5NS_CYC = (TB_5NS_PS / CLOCK_PERIOD_PS) < 1 ? 1
                                : (TB_5NS_PS / CLOCK_PERIOD_PS);

    localparam logic [1:0] TB_MILLI    = 2'h0;
    localparam logic [1:0] TB_MICRO    = 2'h1;
    localparam logic [1:0] TB_FIVE_NS  = 2'h2;

    localparam int TICK_COUNT_W = 14;
    localparam int PRESCALE_W   = 18;

endpackage

/* File: mcgw_tick_gen.sv */
`timescale 1ns/1ps

// ********************************************************************
// watchdog tick prescaler
// ********************************************************************
module mcgw_tick_gen #(
    parameter int TICK_MS_CYCLES = mcgw_pkg::TICK_1MS_CYC,
    parameter int TICK_US_CYCLES = mcgw_pkg::TICK_1US_CYC,
    parameter int TICK_NS_CYCLES = mcgw_pkg::TICK_5NS_CYC
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [1:0] timeBase,
    // tick out
    output logic            tick
);

    logic [mcgw_pkg::PRESCALE_W-1:0] prescale;
    logic [mcgw_pkg::PRESCALE_W-1:0] limit;
    logic                            limitValid;
    logic                            atLimit;

    // tick period per time base; reserved code gives no ticks
    assign limitValid = (timeBase != 2'h3);
    assign limit = (timeBase == mcgw_pkg::TB_MILLI)
                 ? mcgw_pkg::PRESCALE_W'(TICK_MS_CYCLES - 1)
                 : (timeBase == mcgw_pkg::TB_MICRO)
                 ? mcgw_pkg::PRESCALE_W'(TICK_US_CYCLES - 1)
                 : mcgw_pkg::PRESCALE_W'(TICK_NS_CYCLES - 1);
    assign atLimit = limitValid && (prescale >= limit);
    assign tick    = run && atLimit;

    // prescaler holds while not running, restarts with the count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale <= '0;
        end else if (restart || tick) begin
            prescale <= '0;
        end else if (run && limitValid) begin
            prescale <= prescale + 1'b1;
        end
    end

endmodule

/* File: mcgw_wd_asserts.sv */
`timescale 1ns/1ps

// ********************************************************************
// port checks for the global check and watchdog block
// ********************************************************************
module mcgw_wd_asserts #(
    parameter int BANK_COUNT     = 6,
    parameter bit GLOBAL_PRESENT = 1'b1
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // register port
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [31:0] regAddr,
    input wire logic [63:0] regWriteData,
    input wire logic [63:0] regReadData,
    input wire logic        regHit,
    // core side
    input wire logic        haltState,
    input wire logic        errorEvent,
    input wire logic        checkException,
    input wire logic        shutdown,
    input wire logic        watchdogExpired
);
    // decoded requests; 0x200 is the bench's unmapped probe
    wire logic [63:0] capWord = {55'h0, GLOBAL_PRESENT, 8'(BANK_COUNT)};
    wire logic        capRead = regRead && regAddr == mcgw_pkg::ADDR_CAPABILITIES;
    wire logic        badRead = regRead && regAddr == 32'h0000_0200;
    wire logic        wdOff   = regWrite && regAddr == mcgw_pkg::ADDR_TIMEOUT_CFG
                                && !regWriteData[0];

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_cap_read;
        capRead |-> regHit ##1 regReadData == capWord;
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("capability word wrong");
    property p_unmapped;
        badRead |-> !regHit ##1 regReadData == 64'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_exc_single;
        checkException |=> !checkException;
    endproperty
    a_exc_single: assert property (p_exc_single) else $error("nested exception");
    property p_shut_sticky;
        shutdown |=> shutdown;
    endproperty
    a_shut_sticky: assert property (p_shut_sticky) else $error("shutdown dropped");
    property p_shut_cause;
        $rose(shutdown) |-> $past(errorEvent) || $past(watchdogExpired) || watchdogExpired;
    endproperty
    a_shut_cause: assert property (p_shut_cause) else $error("shutdown uncaused");
    property p_exc_cause;
        checkException |-> $past(errorEvent) || $past(watchdogExpired) || watchdogExpired;
    endproperty
    a_exc_cause: assert property (p_exc_cause) else $error("exception uncaused");
    property p_halt;
        haltState [*3] |-> !watchdogExpired;
    endproperty
    a_halt: assert property (p_halt) else $error("expiry while halted");
    property p_wd_off;
        wdOff |=> ##1 !watchdogExpired [*8];
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("expiry while disabled");
endmodule

bind mcgw_machine_check_global_watchdog mcgw_wd_asserts #(
    .BANK_COUNT(BANK_COUNT), .GLOBAL_PRESENT(GLOBAL_PRESENT)
) mcgw_wd_asserts_inst (
    .clock(clock), .rst(rst), .regRead(regRead), .regWrite(regWrite),
    .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
    .regHit(regHit), .haltState(haltState), .errorEvent(errorEvent),
    .checkException(checkException), .shutdown(shutdown),
    .watchdogExpired(watchdogExpired)
);

/* File: mcgw_machine_check_global_watchdog_bench.sv */
`timescale 1ns/1ps

// ********************************************************************
// self-checking bench
// ********************************************************************
module mcgw_machine_check_global_watchdog_bench;
    localparam logic [31:0] CFG = mcgw_pkg::ADDR_TIMEOUT_CFG;
    localparam logic [31:0] GST = mcgw_pkg::ADDR_GLOBAL_STATE;
    localparam logic [31:0] BEN = mcgw_pkg::ADDR_BANK_ENABLE;
    localparam logic [31:0] CAP = mcgw_pkg::ADDR_CAPABILITIES;
    // design ports; inputs driven from the bench, outputs driven by the design
    logic        clock = 1'b0, rst = 1'b1, coldReset = 1'b1, regRead = 1'b0;
    logic        regWrite = 1'b0, regHit, instrComplete = 1'b0, haltState = 1'b0;
    logic [31:0] regAddr = 32'h0;
    logic [63:0] regWriteData = 64'h0, regReadData;
    logic        stopGrantState = 1'b0, errorEvent = 1'b0, errorRestartable = 1'b0;
    logic        errorAtPointer = 1'b0, checkException, shutdown, watchdogExpired;
    logic [5:0]  bankReportControl = 6'h00;
    // bench state
    int          nFail = 0, samplesChecked = 0;
    logic        excSeen = 1'b0, expSeen = 1'b0;
    int          cnt [10] = '{4095, 2047, 1023, 511, 255, 127, 63, 31, 8191, 16383};

    mcgw_machine_check_global_watchdog #(
        .BANK_COUNT(6), .WATCHDOG_BANK(0), .GLOBAL_PRESENT(1'b1),
        .TICK_MS_CYCLES(4), .TICK_US_CYCLES(2)
    ) mcgw_machine_check_global_watchdog_inst (
        .clock(clock), .rst(rst), .coldReset(coldReset), .regRead(regRead),
        .regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData),
        .regReadData(regReadData), .regHit(regHit), .instrComplete(instrComplete),
        .haltState(haltState), .stopGrantState(stopGrantState), .errorEvent(errorEvent),
        .errorRestartable(errorRestartable), .errorAtPointer(errorAtPointer),
        .bankReportControl(bankReportControl), .checkException(checkException),
        .shutdown(shutdown), .watchdogExpired(watchdogExpired)
    );

    // 250 MHz clock
    initial begin
        forever #2 clock = ~clock;
    end
    // sticky event flags; sampled after the edge so pulses are settled
    always @(posedge clock) begin
        #1;
        if (checkException === 1'b1) excSeen = 1'b1;
        if (watchdogExpired === 1'b1) expSeen = 1'b1;
    end

    // ****************************************************************
    // access tasks; all start and end at a falling edge
    // ****************************************************************
    task automatic completeRun();
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wr(input logic [31:0] a, input logic [63:0] d);
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        cyc(1);
        regWrite = 1'b0;
        // one idle edge keeps back-to-back strobes apart
        cyc(1);
    endtask
    task automatic rd(input logic [31:0] a, input logic [63:0] exp, input logic hit);
        regAddr = a;
        regRead = 1'b1;
        #1 chk("hit", hit, regHit);
        cyc(1);
        regRead = 1'b0;
        chk("read", exp, regReadData);
        cyc(1);
    endtask
    task automatic err(input logic r, input logic p);
        errorRestartable = r;
        errorAtPointer = p;
        errorEvent = 1'b1;
        cyc(1);
        errorEvent = 1'b0;
    endtask
    // restart from a cleared counter, as disabling clears it
    task automatic wdCfg(input logic [3:0] cs, input logic [1:0] tb, input logic en);
        wr(CFG, 64'h0);
        wr(CFG, {57'h0, cs, tb, en});
    endtask
    // lo of zero means no expiry is allowed inside the window
    task automatic wdWait(input int lo, input int hi);
        int n;
        n = 0;
        while (watchdogExpired !== 1'b1 && n < hi) begin
            cyc(1);
            n++;
        end
        if (lo == 0) begin
            chk("expiry", 0, watchdogExpired);
        end else if (n >= hi) begin
            nFail++;
            $display("wrong value expiry wait expected %0d seen timeout", lo);
            completeRun();
        end else begin
            chk("expiry time", 1, n >= lo);
        end
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        cyc(4);
        rst = 1'b0;
        coldReset = 1'b0;
        rd(CAP, 64'h106, 1'b1);
        wr(CAP, '1);
        rd(CAP, 64'h106, 1'b1);
        rd(32'h0000_0200, 64'h0, 1'b0);
        rd(GST, 64'h0, 1'b1);
        wr(BEN, '1);
        rd(BEN, 64'h3F, 1'b1);
        wr(CFG, 64'h7E);
        rd(CFG, 64'h7E, 1'b1);
        // nested errors end in shutdown unless software clears in-progress
        err(1'b1, 1'b0);
        chk("exception", 1, checkException);
        rd(GST, 64'h5, 1'b1);
        wr(GST, 64'h0);
        err(1'b0, 1'b1);
        rd(GST, 64'h6, 1'b1);
        err(1'b1, 1'b1);
        chk("shutdown", 1, shutdown);
        chk("exception", 0, checkException);
        // warm reset keeps the error record
        rst = 1'b1;
        cyc(4);
        rst = 1'b0;
        chk("shutdown", 0, shutdown);
        rd(GST, 64'h6, 1'b1);
        rd(BEN, 64'h3F, 1'b1);
        wr(GST, 64'h0);
        // count selects 0 to 9 on the 5 ns tick, reporting gated off
        excSeen = 1'b0;
        for (int i = 0; i < 10; i++) begin
            wdCfg(4'(i), 2'b10, 1'b1);
            wdWait(cnt[i] - 1, cnt[i] + 5);
        end
        chk("exception", 0, excSeen);
        wdCfg(4'h7, 2'b00, 1'b1);
        wdWait(123, 129);
        wdCfg(4'h7, 2'b01, 1'b1);
        wdWait(61, 67);
        wdCfg(4'h7, 2'b11, 1'b1);
        wdWait(0, 300);
        wdCfg(4'hA, 2'b10, 1'b1);
        wdWait(0, 300);
        wdCfg(4'h7, 2'b10, 1'b0);
        wdWait(0, 300);
        // completions inside the period keep restarting the count
        wdCfg(4'h7, 2'b10, 1'b1);
        expSeen = 1'b0;
        repeat (10) begin
            cyc(20);
            instrComplete = 1'b1;
            cyc(1);
            instrComplete = 1'b0;
        end
        chk("expiry", 0, expSeen);
        // halt, then stop-grant, freeze the count
        for (int s = 0; s < 2; s++) begin
            haltState = (s == 0);
            stopGrantState = (s == 1);
            wdCfg(4'h7, 2'b10, 1'b1);
            wdWait(0, 200);
            haltState = 1'b0;
            stopGrantState = 1'b0;
            wdWait(30, 37);
        end
        // expiry reported only with both enables set
        for (int g = 1; g >= 0; g--) begin
            bankReportControl = 6'h01;
            wr(BEN, g ? 64'h3F : 64'h0);
            excSeen = 1'b0;
            wdCfg(4'h7, 2'b10, 1'b1);
            wdWait(30, 37);
            cyc(2);
            wr(CFG, 64'h0);
            chk("exception", g, excSeen);
            rd(GST, g ? 64'h4 : 64'h0, 1'b1);
            wr(GST, 64'h0);
        end
        completeRun();
    end
endmodule
